// file: crc_channel.sv
// Overview of operation
// - Control word with test bit in normal mode enters test mode and halts sequencing.
// - In test mode each command loads the complemented data word as microinstruction.
// - Each test-mode load issues exactly one single-step clock pulse.
// - Test mode ends on the reset-test microinstruction or on master clear.
// - In test mode every function code is treated alike as a load.
// - In test mode input commands get no response.
// - Test mode suspends the whole channel's service.
// - Card data goes by DMA; end of range raises an interrupt.
// - Binary mode puts twelve row bits right-justified, one word per column.
// - Binary mode forces the top four bits to zero.
// - Binary mode accepts every hole pattern without code error.
// - ASCII mode translates each column to one byte, two bytes per word.
// - Untranslatable ASCII columns set status bit 8 code error.
// - Empty hopper or full stacker reported as status with reader reset.
// - At most four reader ports; the channel answers only its own port.
// - Function code 26 returns the sixteen-bit identification number.
// - Control word command is never refused even while busy.
// - ASCII bit 8 lands on bus bit 0 of its byte, bit 1 on bit 7.
//
// The address map and the Avalon-MM slave port were left to the implementer.
`default_nettype none
module crc_channel
    import crc_pkg::*;
(
    input  wire logic        CLK,             // 40 MHz clock.
    input  wire logic        RESET,           // Asynchronous, active high.
    input  wire logic [7:0]  AVS_ADDRESS,     // Byte address.
    input  wire logic        AVS_READ,        // Read request.
    input  wire logic        AVS_WRITE,       // Write request.
    input  wire logic [31:0] AVS_WRITEDATA,   // Write data.
    input  wire logic [3:0]  AVS_BYTEENABLE,  // Byte lanes.
    output logic      [31:0] AVS_READDATA,    // Read data.
    output logic             AVS_WAITREQUEST, // Stall.
    input  wire crc_rdr_t    RDR,             // Reader adapter pins.
    output logic             DMA_VALID,       // DMA word offered.
    input  wire logic        DMA_READY,       // Memory takes the word.
    output crc_dma_t         DMA_OUT,         // DMA address and data.
    output logic             EOR_IRQ,         // End-of-range pulse.
    output logic             TEST_MODE,       // Test mode active.
    output logic             UI_STEP,         // Single-step clock pulse.
    output logic      [15:0] UI_WORD          // Microinstruction register.
);

    typedef struct packed {
        crc_rdr_t    rdr1;
        crc_rdr_t    rdr2;
        logic        strobe3;
        logic        end3;
        logic        ack;
        logic [31:0] rdata;
        logic [23:0] cmd_data;
        logic [18:0] resp;
        logic        test;
        logic        step;
        logic [15:0] uinstr;
        logic        busy;
        logic        binary;
        logic        freeze;
        logic [23:0] addr;
        logic [15:0] range;
        crc_ch_t     ch;
        logic [15:0] word;
        logic        half;
        logic        last;
        logic        ascii_err;
        logic        svc_err;
        logic        irq;
        logic        dma_valid;
    } crc_state_t;

    crc_state_t q;
    crc_state_t d;

    // Card code to ASCII, returning {valid, byte}; rows 12,11,0,1..9 map to bits 11..0.
    function automatic logic [8:0] h2a(input logic [11:0] c);
        logic [2:0] z;
        logic       p8;
        logic [8:0] r;
        logic [3:0] g;
        logic [4:0] n;
        z = c[11:9];
        p8 = c[1];
        r = 9'h000;
        g = 4'h0;
        n = 5'd0;
        for (int i = 0; i < 9; i++)
        begin
            if (i != 7 && c[8-i])
            begin
                g = 4'(i + 1);
                n = n + 5'd1;
            end
        end
        if (n > 5'd1)
            r = 9'h000;
        else if (!p8)
        begin
            unique case (z)
                3'b000: r = (n == 5'd0) ? 9'h120 : {1'b1, 8'h30 + 8'(g)};
                3'b100: r = (n == 5'd0) ? 9'h126 : {1'b1, 8'h40 + 8'(g)};
                3'b010: r = (n == 5'd0) ? 9'h12d : {1'b1, 8'h49 + 8'(g)};
                3'b001: r = (n == 5'd0) ? 9'h130 :
                            (g == 4'h1) ? 9'h12f : {1'b1, 8'h51 + 8'(g)};
                default: r = 9'h000;
            endcase
        end
        else if (n == 5'd0 && z == 3'b000)
            r = 9'h138;
        else if (n == 5'd1 && g >= 4'h2 && g <= 4'h7)
        begin
            unique case (z)
                3'b000: r = {1'b1, 8'(48'h3a2340273d22 >> (8 * (7 - g)))};
                3'b100: r = {1'b1, 8'(48'h5b2e3c282b21 >> (8 * (7 - g)))};
                3'b010: r = {1'b1, 8'(48'h5d242a293b5e >> (8 * (7 - g)))};
                3'b001: r = {1'b1, 8'(48'h5c2c255f3e3f >> (8 * (7 - g)))};
                default: r = 9'h000;
            endcase
        end
        return r;
    endfunction

    logic        acc;
    logic        wr;
    logic        cmd;
    logic [5:0]  fc;
    logic [15:0] cw;
    logic [15:0] stat;
    logic        col_ev;
    logic        end_ev;
    logic [8:0]  xl;
    logic [15:0] used;

    // Bus decode, status word and synchronised reader events.
    always_comb
    begin
        acc = (AVS_READ || AVS_WRITE) && q.ack;
        wr = acc && AVS_WRITE && AVS_BYTEENABLE[0];
        cmd = wr && AVS_ADDRESS == REG_CMD;
        fc = AVS_WRITEDATA[CMD_FC_LSB +: 6];
        cw = q.cmd_data[15:0];
        stat = 16'h0000;
        stat[ST_READY_BIT] = q.rdr2.ready;
        stat[ST_ATTN_BIT] = q.rdr2.hopper_empty || q.rdr2.stacker_full || q.rdr2.reset_ind;
        stat[ST_SVC_BIT] = q.svc_err;
        stat[ST_ASCII_BIT] = q.ascii_err;
        col_ev = q.rdr2.strobe && !q.strobe3 && !q.test;
        end_ev = q.rdr2.card_end && !q.end3 && !q.test;
        xl = h2a(q.rdr2.col);
        used = q.binary ? 16'h0002 : 16'h0001;
    end

    // Next-state logic for the whole channel.
    always_comb
    begin
        d = q;
        d.rdr1 = RDR;
        d.rdr2 = q.rdr1;
        d.strobe3 = q.rdr2.strobe;
        d.end3 = q.rdr2.card_end;
        d.ack = (AVS_READ || AVS_WRITE) && !q.ack;
        d.step = 1'b0;
        d.irq = 1'b0;
        // Read data is captured in the stall cycle and shown on the completing edge.
        unique case (AVS_ADDRESS)
            REG_CMD_DATA: d.rdata = {8'h00, q.cmd_data};
            REG_RESP:     d.rdata = {13'h0000, q.resp};
            REG_STATUS:   d.rdata = {13'h0000, q.binary, q.busy, q.test, stat};
            REG_UINSTR:   d.rdata = {16'h0000, q.uinstr};
            default:      d.rdata = 32'h00000000;
        endcase
        // Command data word accepts byte lanes individually.
        if (acc && AVS_WRITE && AVS_ADDRESS == REG_CMD_DATA)
        begin
            for (int b = 0; b < 3; b++)
            begin
                if (AVS_BYTEENABLE[b])
                    d.cmd_data[8*b +: 8] = AVS_WRITEDATA[8*b +: 8];
            end
        end
        // Single-step: the loaded microinstruction runs on the step pulse.
        if (q.step && q.uinstr == UI_RESET_TEST)
            d.test = 1'b0;
        // Command processing for this port only.
        if (cmd && AVS_WRITEDATA[CMD_PORT_LSB +: 2] == CHAN_PORT)
        begin
            d.resp = 19'h00000;
            if (q.test)
            begin
                d.uinstr = ~cw;
                d.step = 1'b1;
                if (fc[0])
                    d.resp[RESP_ACK_BIT] = 1'b1;
            end
            else if (fc == FC_CONTROL)
            begin
                d.resp[RESP_ACK_BIT] = 1'b1;
                d.freeze = cw[CW_FREEZE_BIT];
                if (cw[CW_INIT_BIT])
                begin
                    d.busy = 1'b0;
                    d.binary = RST_BINARY;
                    d.ch = CH_IDLE;
                    d.dma_valid = 1'b0;
                end
                if (cw[CW_STOP_BIT] && q.busy)
                begin
                    d.busy = 1'b0;
                    d.irq = 1'b1;
                    d.ch = CH_IDLE;
                    d.dma_valid = 1'b0;
                end
                if (cw[CW_TEST_BIT])
                begin
                    d.test = 1'b1;
                    d.dma_valid = 1'b0;
                end
            end
            else if (q.busy)
                d.resp[RESP_NAK_BIT] = 1'b1;
            else
            begin
                d.resp[RESP_ACK_BIT] = 1'b1;
                d.resp[RESP_VALID_BIT] = !fc[0];
                unique case (fc)
                    FC_ADDRESS:    d.addr = q.cmd_data;
                    FC_RANGE:
                    begin
                        d.range = cw;
                        d.busy = 1'b1;
                        d.ch = CH_RUN;
                        d.half = 1'b0;
                        d.last = 1'b0;
                        d.ascii_err = 1'b0;
                        d.svc_err = 1'b0;
                    end
                    FC_CFG_OUT:    d.binary = cw[0];
                    FC_ADDR_LO_IN: d.resp[15:0] = q.addr[15:0];
                    FC_ADDR_HI_IN: d.resp[15:0] = {8'h00, q.addr[23:16]};
                    FC_RANGE_IN:   d.resp[15:0] = q.range;
                    FC_CFG_IN:     d.resp[15:0] = {15'h0000, q.binary};
                    FC_STATUS_IN:  d.resp[15:0] = stat;
                    FC_ID_IN:      d.resp[15:0] = DEVICE_ID;
                    default:       d.resp = 19'h00000;
                endcase
            end
        end
        // Channel sequencer, frozen while test mode holds the controller.
        if (!q.test)
        begin
            unique case (q.ch)
                CH_IDLE:
                begin
                    d.half = 1'b0;
                end
                CH_RUN:
                begin
                    if (col_ev)
                    begin
                        d.range = (q.range > used) ? q.range - used : 16'h0000;
                        d.last = q.range <= used || end_ev;
                        if (q.binary)
                        begin
                            d.word = {4'h0, q.rdr2.col};
                            d.ch = CH_DMA;
                            d.dma_valid = 1'b1;
                        end
                        else
                        begin
                            if (!xl[8])
                                d.ascii_err = 1'b1;
                            if (!q.half)
                                d.word = {xl[7:0], 8'h00};
                            else
                                d.word = {q.word[15:8], xl[7:0]};
                            d.half = !q.half;
                            if (q.half || q.range <= used || end_ev)
                            begin
                                d.ch = CH_DMA;
                                d.dma_valid = 1'b1;
                            end
                        end
                    end
                    else if (end_ev)
                    begin
                        d.last = 1'b1;
                        d.ch = q.half ? CH_DMA : CH_IDLE;
                        d.dma_valid = q.half;
                        d.busy = q.half;
                        d.irq = !q.half;
                    end
                end
                CH_DMA:
                begin
                    if (col_ev)
                        d.svc_err = 1'b1;
                    if (DMA_READY)
                    begin
                        d.dma_valid = 1'b0;
                        d.half = 1'b0;
                        if (!q.freeze)
                            d.addr = q.addr + 24'h000002;
                        d.ch = q.last ? CH_IDLE : CH_RUN;
                        d.busy = !q.last;
                        d.irq = q.last;
                    end
                end
                default: d.ch = CH_IDLE;
            endcase
        end
        // Master clear from software ends test mode and idles the channel.
        if (wr && AVS_ADDRESS == REG_CTRL && AVS_WRITEDATA[0])
        begin
            d.test = 1'b0;
            d.step = 1'b0;
            d.busy = 1'b0;
            d.ch = CH_IDLE;
            d.dma_valid = 1'b0;
        end
    end

    // State register.
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            q <= '0;
            q.binary <= RST_BINARY;
            q.addr <= RST_ADDR;
            q.range <= RST_RANGE;
            q.ch <= CH_IDLE;
        end
        else
            q <= d;
    end

    // Port drive.
    assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !q.ack;
    assign AVS_READDATA = q.rdata;
    assign DMA_VALID = q.dma_valid;
    assign DMA_OUT.addr = q.addr;
    assign DMA_OUT.data = q.word;
    assign EOR_IRQ = q.irq;
    assign TEST_MODE = q.test;
    assign UI_STEP = q.step;
    assign UI_WORD = q.uinstr;

    // Test-mode entry on a control word with the test bit.
    property p_test_entry;
        @(posedge CLK) disable iff (RESET)
        (cmd && !q.test && fc == FC_CONTROL && cw[CW_TEST_BIT] &&
         AVS_WRITEDATA[CMD_PORT_LSB +: 2] == CHAN_PORT && !AVS_WRITEDATA[0] == 1'b0)
        |=> TEST_MODE;
    endproperty
    a_test_entry: assert property (p_test_entry) else $error("test mode not entered");

    // Load holds the complement of the data word.
    property p_load;
        @(posedge CLK) disable iff (RESET)
        (cmd && q.test && AVS_WRITEDATA[CMD_PORT_LSB +: 2] == CHAN_PORT) |=> UI_WORD == ~$past(cw);
    endproperty
    a_load: assert property (p_load) else $error("microinstruction not complemented");

    // Exactly one step pulse per load.
    property p_one_step;
        @(posedge CLK) disable iff (RESET)
        UI_STEP |=> !UI_STEP;
    endproperty
    a_one_step: assert property (p_one_step) else $error("step pulse too long");

    // Reset-test microinstruction leaves test mode.
    property p_leave;
        @(posedge CLK) disable iff (RESET)
        (UI_STEP && UI_WORD == UI_RESET_TEST && !cmd) |=> !TEST_MODE;
    endproperty
    a_leave: assert property (p_leave) else $error("test mode not left");

    // Inputs in test mode leave no response.
    property p_no_resp;
        @(posedge CLK) disable iff (RESET)
        (cmd && q.test && !fc[0] && AVS_WRITEDATA[CMD_PORT_LSB +: 2] == CHAN_PORT)
        |=> q.resp == 19'h00000;
    endproperty
    a_no_resp: assert property (p_no_resp) else $error("response in test mode");

    // No DMA and no step of the sequencer while in test mode.
    property p_suspend;
        @(posedge CLK) disable iff (RESET)
        (TEST_MODE && !$rose(TEST_MODE)) |-> !DMA_VALID && $stable(q.ch);
    endproperty
    a_suspend: assert property (p_suspend) else $error("channel ran in test mode");

    // A DMA word stands until memory takes it.
    property p_dma_hold;
        @(posedge CLK) disable iff (RESET)
        (DMA_VALID && !DMA_READY && !cmd && !wr) |=> DMA_VALID && $stable(DMA_OUT);
    endproperty
    a_dma_hold: assert property (p_dma_hold) else $error("DMA word dropped");

    // Binary words carry zero in the four top bits.
    property p_binary_top;
        @(posedge CLK) disable iff (RESET)
        (DMA_VALID && q.binary) |-> DMA_OUT.data[15:12] == 4'h0;
    endproperty
    a_binary_top: assert property (p_binary_top) else $error("binary top bits set");

    // Binary columns never raise a code error.
    property p_binary_ok;
        @(posedge CLK) disable iff (RESET)
        (q.binary && !q.ascii_err && !cmd) |=> !q.ascii_err;
    endproperty
    a_binary_ok: assert property (p_binary_ok) else $error("code error in binary");

    // A control word is never refused.
    property p_ctl_ack;
        @(posedge CLK) disable iff (RESET)
        (cmd && !q.test && fc == FC_CONTROL && AVS_WRITEDATA[CMD_PORT_LSB +: 2] == CHAN_PORT)
        |=> q.resp[RESP_ACK_BIT] && !q.resp[RESP_NAK_BIT];
    endproperty
    a_ctl_ack: assert property (p_ctl_ack) else $error("control word refused");

endmodule
`default_nettype wire

// file: crc_pkg.sv
`default_nettype none
package crc_pkg;
    // Register byte offsets on the Avalon-MM slave.
    localparam logic [7:0]  REG_CMD_DATA   = 8'h00;
    localparam logic [7:0]  REG_CMD        = 8'h04;
    localparam logic [7:0]  REG_RESP       = 8'h08;
    localparam logic [7:0]  REG_CTRL       = 8'h0c;
    localparam logic [7:0]  REG_STATUS     = 8'h10;
    localparam logic [7:0]  REG_UINSTR     = 8'h14;
    // Command register fields.
    localparam int          CMD_FC_LSB     = 0;
    localparam int          CMD_PORT_LSB   = 8;
    // Response register flag positions.
    localparam int          RESP_VALID_BIT = 16;
    localparam int          RESP_ACK_BIT   = 17;
    localparam int          RESP_NAK_BIT   = 18;
    // Function codes.
    localparam logic [5:0]  FC_CONTROL     = 6'h01;
    localparam logic [5:0]  FC_ADDRESS     = 6'h09;
    localparam logic [5:0]  FC_RANGE       = 6'h0d;
    localparam logic [5:0]  FC_CFG_OUT     = 6'h11;
    localparam logic [5:0]  FC_ADDR_LO_IN  = 6'h08;
    localparam logic [5:0]  FC_ADDR_HI_IN  = 6'h0a;
    localparam logic [5:0]  FC_RANGE_IN    = 6'h0c;
    localparam logic [5:0]  FC_CFG_IN      = 6'h10;
    localparam logic [5:0]  FC_STATUS_IN   = 6'h18;
    localparam logic [5:0]  FC_ID_IN       = 6'h26;
    // Control word bits (bus bit 0 is the word's most significant bit).
    localparam int          CW_INIT_BIT    = 15;
    localparam int          CW_STOP_BIT    = 14;
    localparam int          CW_TEST_BIT    = 13;
    localparam int          CW_FREEZE_BIT  = 12;
    // Status word bits.
    localparam int          ST_READY_BIT   = 15;
    localparam int          ST_ATTN_BIT    = 14;
    localparam int          ST_SVC_BIT     = 13;
    localparam int          ST_ASCII_BIT   = 7;
    // This channel's adapter port out of the four.
    localparam logic [1:0]  CHAN_PORT      = 2'h0;
    // Identification number; the value is arbitrary.
    localparam logic [15:0] DEVICE_ID      = 16'h5a5a;
    // Microinstruction that leaves test mode; the value is arbitrary.
    localparam logic [15:0] UI_RESET_TEST  = 16'h0f0f;
    // Reset values.
    localparam logic        RST_BINARY     = 1'b0;
    localparam logic [15:0] RST_RANGE      = 16'h0000;
    localparam logic [23:0] RST_ADDR       = 24'h000000;

    // Channel sequencer states.
    typedef enum logic [2:0] {
        CH_IDLE = 3'b001,
        CH_RUN  = 3'b010,
        CH_DMA  = 3'b100
    } crc_ch_t;

    // Reader adapter pins.
    typedef struct packed {
        logic [11:0] col;
        logic        strobe;
        logic        card_end;
        logic        hopper_empty;
        logic        stacker_full;
        logic        reset_ind;
        logic        ready;
    } crc_rdr_t;

    // DMA write request toward memory.
    typedef struct packed {
        logic [23:0] addr;
        logic [15:0] data;
    } crc_dma_t;
endpackage
`default_nettype wire

// file: crc_rdr_model.sv
`default_nettype none
module crc_rdr_model
    import crc_pkg::*;
(
    input  wire logic CLK, // Bench clock.
    input  wire logic HOP, // Input hopper empty.
    output var crc_rdr_t RDR // Reader pins toward the channel.
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [11:0] col_q;
    logic        stb_q;
    // The reader starts idle with no strobe.
    initial
    begin
        col_q = 12'h000;
        stb_q = 1'b0;
    end
    // Pins as the adapter drives them; the reader is always powered and ready.
    always_comb RDR = '{col: col_q, strobe: stb_q, card_end: 1'b0, hopper_empty: HOP,
                        stacker_full: 1'b0, reset_ind: 1'b0, ready: 1'b1};
    // Sets up one column, pulses the strobe, then scrambles the stale lines.
    task automatic punch(input logic [11:0] c);
        @(posedge CLK);
        col_q <= c;
        @(posedge CLK);
        stb_q <= 1'b1;
        repeat (4) @(posedge CLK);
        stb_q <= 1'b0;
        repeat (2) @(posedge CLK);
        col_q <= ~c;
    endtask
endmodule
`default_nettype wire

// file: tb.sv
`default_nettype none
module tb
    import crc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk;
    logic        reset;
    logic [7:0]  aa;
    logic        ard;
    logic        awr;
    logic [31:0] awd;
    logic [31:0] ard_d;
    logic        await;
    crc_rdr_t    rdr;
    logic        dv;
    logic        drdy;
    crc_dma_t    dout;
    logic        eor;
    logic        tm;
    logic        ust;
    logic [15:0] uw;
    logic        hop;
    int          err_total;
    int          checks_done;
    int          steps;
    int          eors;
    int          n0;
    integer      seed;
    crc_dma_t    dq[$];
    logic [31:0] r;
    logic [11:0] cols[3];
    logic [15:0] d16;
    logic [23:0] base;
    logic [5:0]  f;
    logic [3:0]  a;
    logic [3:0]  b;

    crc_channel uut (.CLK(clk), .RESET(reset), .AVS_ADDRESS(aa), .AVS_READ(ard),
        .AVS_WRITE(awr), .AVS_WRITEDATA(awd), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(ard_d),
        .AVS_WAITREQUEST(await), .RDR(rdr), .DMA_VALID(dv), .DMA_READY(drdy),
        .DMA_OUT(dout), .EOR_IRQ(eor), .TEST_MODE(tm), .UI_STEP(ust), .UI_WORD(uw));
    crc_rdr_model m (.CLK(clk), .HOP(hop), .RDR(rdr));

    // Free-running 40 MHz clock.
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Collects taken DMA words, counts pulses and lets memory stall at random.
    always @(posedge clk)
    begin
        if (dv === 1'b1 && drdy === 1'b1)
            dq.push_back(dout);
        if (eor === 1'b1)
            eors++;
        if (ust === 1'b1)
            steps++;
        drdy <= ($random(seed) % 4) != 0;
    end

    // Counts a comparison and reports a difference.
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            err_total++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask

    // One Avalon-MM access, held until waitrequest is sampled low.
    task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk);
        aa  <= ad;
        awr <= wr;
        ard <= !wr;
        awd <= d;
        // Only the watchdog ends a wait that never sees waitrequest low.
        do
            @(posedge clk);
        while (await !== 1'b0);
        r = ard_d;
        ard <= 1'b0;
        awr <= 1'b0;
    endtask

    // Sends one command to a port and fetches the response word.
    task automatic cmd(input logic [5:0] fc, input logic [23:0] d, input logic [1:0] p = 2'h0);
        bus(1'b1, REG_CMD_DATA, {8'h00, d});
        bus(1'b1, REG_CMD, {22'h0, p, 2'h0, fc});
        repeat (2) @(posedge clk);
        bus(1'b0, REG_RESP, 32'h0);
    endtask

    // Waits a bounded time for the collected word count to reach k.
    task automatic wait_dq(input int k);
        for (int n = 0; n < 300 && dq.size() < k; n++)
            @(posedge clk);
    endtask

    // Card column that punches a single decimal digit.
    function automatic logic [11:0] dcol(input logic [3:0] d);
        return (d == 4'h0) ? 12'h200 : 12'(12'h200 >> d);
    endfunction

    // Prints the verdict and stops.
    task automatic end_sim;
        if (err_total == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Cuts a hang short.
    initial
    begin
        #500000;
        err_total++;
        end_sim();
    end

    // Main sequence.
    initial
    begin
        seed = 32'hbf2023e8;
        {err_total, checks_done} = '0;
        {reset, aa, ard, awr, awd, hop} = {1'b1, 43'h0};
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        bus(1'b0, REG_STATUS, 32'h0);
        chk("stat_rst", 32'h0, {29'h0, r[18:16]});
        bus(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h0, r);
        cmd(FC_ID_IN, 24'h0);
        chk("dev_id", {15'h0, 1'b1, DEVICE_ID}, {15'h0, r[16:0]});
        cmd(FC_STATUS_IN, 24'h0, 2'h1);
        chk("port1", {15'h0, 1'b1, DEVICE_ID}, {15'h0, r[16:0]});
        hop <= 1'b1;
        repeat (4) @(posedge clk);
        bus(1'b0, REG_STATUS, 32'h0);
        chk("attn", 32'h1, {31'h0, r[ST_ATTN_BIT]});
        hop <= 1'b0;
        for (int run = 0; run < 2; run++)
        begin
            // The second run freezes the DMA address, so every word lands at the base.
            cmd(FC_CONTROL, 24'(run) << CW_FREEZE_BIT);
            cmd(FC_CFG_OUT, 24'h1);
            base = {8'h00, 15'($random(seed)), 1'b0};
            cmd(FC_ADDRESS, base);
            cmd(FC_RANGE, 24'(6 + 2 * run));
            cmd(FC_STATUS_IN, 24'h0);
            chk("busy_nak", 32'h1, {31'h0, r[RESP_NAK_BIT]});
            dq.delete();
            for (int k = 0; k < 3; k++)
            begin
                cols[k] = (k == 0) ? 12'hfff : 12'($random(seed));
                m.punch(cols[k]);
                wait_dq(k + 1);
                chk("bin_data", {20'h0, cols[k]}, {16'h0, dq[k].data});
                chk("bin_addr", {8'h0, base + 24'(2 * k * (1 - run))}, {8'h0, dq[k].addr});
            end
            repeat (4) @(posedge clk);
            if (run == 0)
            begin
                bus(1'b0, REG_STATUS, 32'h0);
                chk("eor", 32'h1, 32'(eors));
                chk("bin_stat", 32'h0, {30'h0, r[17], r[ST_ASCII_BIT]});
            end
        end
        cmd(FC_CONTROL, 24'h1 << CW_TEST_BIT);
        chk("ctl_ack", 32'h1, {31'h0, r[RESP_ACK_BIT]});
        chk("test_on", 32'h1, {31'h0, tm});
        m.punch(12'h5a5);
        repeat (10) @(posedge clk);
        chk("frozen", 32'd3, 32'(dq.size()));
        for (int j = 0; j < 6; j++)
        begin
            f = (j == 0) ? FC_STATUS_IN : 6'($random(seed));
            d16 = 16'($random(seed));
            if (d16 == ~UI_RESET_TEST)
                d16 = d16 ^ 16'h0001;
            n0 = steps;
            cmd(f, {8'h00, d16});
            chk("ui_word", {16'h0, ~d16}, {16'h0, uw});
            chk("ui_step", 32'(n0 + 1), 32'(steps));
            chk("no_resp", {14'h0, f[0], 17'h0}, r);
        end
        cmd(FC_CONTROL, {8'h00, ~UI_RESET_TEST});
        chk("test_off", 32'h0, {31'h0, tm});
        cmd(FC_CONTROL, 24'h1 << CW_TEST_BIT);
        bus(1'b1, REG_CTRL, 32'h1);
        repeat (2) @(posedge clk);
        chk("mclr", 32'h0, {31'h0, tm});
        cmd(FC_CFG_OUT, 24'h0);
        cmd(FC_ADDRESS, 24'h000100);
        cmd(FC_RANGE, 24'h2);
        dq.delete();
        a = 4'($unsigned($random(seed)) % 10);
        b = 4'($unsigned($random(seed)) % 10);
        m.punch(dcol(a));
        m.punch(dcol(b));
        wait_dq(1);
        chk("ascii", {16'h0, 8'h30 + {4'h0, a}, 8'h30 + {4'h0, b}}, {16'h0, dq[0].data});
        cmd(FC_RANGE, 24'h1);
        m.punch(12'h180);
        wait_dq(2);
        repeat (4) @(posedge clk);
        bus(1'b0, REG_STATUS, 32'h0);
        chk("code_err", 32'h1, {31'h0, r[ST_ASCII_BIT]});
        // Stop with initialise while busy idles the channel and raises one interrupt.
        cmd(FC_RANGE, 24'h4);
        cmd(FC_CONTROL, (24'h1 << CW_STOP_BIT) | (24'h1 << CW_INIT_BIT));
        bus(1'b0, REG_STATUS, 32'h0);
        chk("stop_eor", 32'h4, 32'(eors));
        chk("stop_idle", 32'h0, {30'h0, r[18:17]});
        end_sim();
    end
endmodule
`default_nettype wire
